// >>> rtl/scg_pkg.sv
// constants and types for the sleep-mode clock gating control block
// assumes one system clock and one synchronous active-low reset
//
// Summary of operation
// RL1 - 32-bit gating register at 0x114, resets zero
// RL2 - set bit clocks unit, clear bit disables
// RL3 - access to unclocked unit answers bus fault
// RL4 - all gating bits start zero; software enables
// RL5 - sleep values apply only with auto-gate select
// RL6 - bits 25/24 gate comparators 1/0
// RL7 - bits 19..16 gate counters 3..0
// RL8 - bits 14/12 gate i2c units 1/0
// RL9 - bits 5/4 gate sync serial 1/0
// RL10 - bits 1/0 gate async serial 1/0
// RL11 - reserved bits read zero, ignore writes
// RL12 - gating bits hold last written value
package scg_pkg;
    localparam int SCG_ADDR_W = 12;
    localparam int SCG_DATA_W = 32;
    localparam int SCG_UNITS = 12;
    localparam logic [SCG_ADDR_W-1:0] SCG_OFS_SLEEP_GATE = 12'h114;
    localparam logic [SCG_DATA_W-1:0] SCG_RST_SLEEP_GATE = 32'h0000_0000;
    localparam logic [SCG_DATA_W-1:0] SCG_RW_MASK = 32'h030f_5033;
    localparam logic [1:0] SCG_RESP_OKAY = 2'h0;
    localparam logic [1:0] SCG_RESP_SLVERR = 2'h2;
    // bit position of each unit in the gating register
    localparam int SCG_BIT_ASYNC0 = 0;
    localparam int SCG_BIT_ASYNC1 = 1;
    localparam int SCG_BIT_SYNC0 = 4;
    localparam int SCG_BIT_SYNC1 = 5;
    localparam int SCG_BIT_I2C_UNIT0_GATE = 12;
    localparam int SCG_BIT_I2C_UNIT1_GATE = 14;
    localparam int SCG_BIT_CNT0 = 16;
    localparam int SCG_BIT_CNT1 = 17;
    localparam int SCG_BIT_CNT2 = 18;
    localparam int SCG_BIT_CNT3 = 19;
    localparam int SCG_BIT_CMP0 = 24;
    localparam int SCG_BIT_CMP1 = 25;
    // unit index order: async0, async1, sync0, sync1, i2c_unit0_gate, i2c_unit1_gate,
    // counter0..3, comparator0, comparator1
    localparam int SCG_UNIT_POS [SCG_UNITS] = '{SCG_BIT_ASYNC0, SCG_BIT_ASYNC1,
        SCG_BIT_SYNC0, SCG_BIT_SYNC1, SCG_BIT_I2C_UNIT0_GATE, SCG_BIT_I2C_UNIT1_GATE, SCG_BIT_CNT0,
        SCG_BIT_CNT1, SCG_BIT_CNT2, SCG_BIT_CNT3, SCG_BIT_CMP0, SCG_BIT_CMP1};

    // per-unit view handed to the peripheral side
    typedef struct packed {
        logic clk_en;
        logic grant;
        logic fault;
    } scg_unit_s;

    // which gating register drives the units
    typedef enum logic [1:0] {
        SCG_SRC_RUN,
        SCG_SRC_SLEEP,
        SCG_SRC_DEEP
    } scg_src_e;
endpackage

// >>> rtl/scg_unit_gate.sv
// one peripheral unit: registered clock enable and access screening
// assumes access_i is a one-cycle strobe from the bus decoder, same clock
`timescale 1ns/1ps
module scg_unit_gate (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic enable_i,
    input wire logic access_i,
    output scg_pkg::scg_unit_s unit_o
);
    import scg_pkg::*;

    scg_unit_s unit;
    scg_unit_s next_unit;

    // the fault decision uses the enable the unit actually runs on,
    // so an access in the cycle of a change sees the old clock state
    always_comb begin
        next_unit.clk_en = enable_i; // [RL2]
        next_unit.grant = access_i & unit.clk_en; // [RL2]
        next_unit.fault = access_i & ~unit.clk_en; // [RL3]
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            unit <= '0; // [RL4]
        end else begin
            unit <= next_unit;
        end
    end

    assign unit_o = unit;
endmodule

// >>> rtl/scg_ctrl.sv
// sleep-mode clock gating register with axi4-lite slave and unit gates
// assumes mode inputs and access strobes come from logic on clk_sys_i
`timescale 1ns/1ps
module scg_ctrl (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // axi4-lite slave
    input wire logic [scg_pkg::SCG_ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [scg_pkg::SCG_DATA_W-1:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [scg_pkg::SCG_ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [scg_pkg::SCG_DATA_W-1:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // system mode and the sibling gating registers
    input wire logic sleep_mode_i,
    input wire logic deep_sleep_mode_i,
    input wire logic auto_clock_gate_select_i,
    input wire logic [scg_pkg::SCG_DATA_W-1:0] run_clock_gate_ctrl_one_i,
    input wire logic [scg_pkg::SCG_DATA_W-1:0] deepsleep_clock_gate_ctrl_one_i,
    // peripheral side
    input wire logic [scg_pkg::SCG_UNITS-1:0] unit_access_i,
    output scg_pkg::scg_unit_s [scg_pkg::SCG_UNITS-1:0] units_o,
    output logic [scg_pkg::SCG_DATA_W-1:0] sleep_clock_gate_ctrl_one_o,
    output scg_pkg::scg_src_e gate_source_o
);
    import scg_pkg::*;

    // write channel state
    logic aw_held;
    logic [SCG_ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [SCG_DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic next_aw_held;
    logic [SCG_ADDR_W-1:0] next_aw_addr;
    logic next_w_held;
    logic [SCG_DATA_W-1:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_bvalid;
    logic [1:0] next_bresp;
    // read channel state
    logic rvalid;
    logic [SCG_DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic next_rvalid;
    logic [SCG_DATA_W-1:0] next_rdata;
    logic [1:0] next_rresp;
    // the gating register itself
    logic [SCG_DATA_W-1:0] sleep_clock_gate_ctrl_one;
    logic [SCG_DATA_W-1:0] next_sleep_clock_gate_ctrl_one;

    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic commit;
    logic wr_hit;
    logic rd_hit;
    logic [SCG_DATA_W-1:0] be_mask;
    scg_src_e src;
    logic [SCG_DATA_W-1:0] sel_gate;
    logic [SCG_UNITS-1:0] unit_en;
    logic [SCG_UNITS-1:0] unit_clk_en;
    logic [SCG_UNITS-1:0] unit_grant;
    logic [SCG_UNITS-1:0] unit_fault;
    logic [SCG_UNITS-1:0] sleep_vec;
    logic [SCG_UNITS-1:0] run_vec;

    // handshakes; a new address may be taken while a response waits
    assign aw_fire = s_axi_awvalid_i & s_axi_awready_o;
    assign w_fire = s_axi_wvalid_i & s_axi_wready_o;
    assign ar_fire = s_axi_arvalid_i & s_axi_arready_o;
    assign commit = aw_held & w_held & ~bvalid;
    // decode ignores the two byte-offset bits
    assign wr_hit = aw_addr[SCG_ADDR_W-1:2] == SCG_OFS_SLEEP_GATE[SCG_ADDR_W-1:2]; // [RL1]
    assign rd_hit = s_axi_araddr_i[SCG_ADDR_W-1:2]
        == SCG_OFS_SLEEP_GATE[SCG_ADDR_W-1:2]; // [RL1]

    // byte lanes from the write strobes
    always_comb begin
        be_mask = '0;
        for (int b = 0; b < 4; b++) begin
            be_mask[b*8 +: 8] = {8{w_strb[b]}};
        end
    end

    // write path: address and data taken in either order, then one response
    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_sleep_clock_gate_ctrl_one = sleep_clock_gate_ctrl_one;
        if (bvalid && s_axi_bready_i) begin
            next_bvalid = 1'b0;
        end
        if (commit) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = wr_hit ? SCG_RESP_OKAY : SCG_RESP_SLVERR;
            if (wr_hit) begin
                // reserved bits are masked so they never leave zero
                next_sleep_clock_gate_ctrl_one = (sleep_clock_gate_ctrl_one
                    & ~(be_mask & SCG_RW_MASK))
                    | (w_data & be_mask & SCG_RW_MASK); // [RL11] [RL12]
            end
        end
        if (aw_fire) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr_i;
        end
        if (w_fire) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata_i;
            next_w_strb = s_axi_wstrb_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
            bvalid <= 1'b0;
            bresp <= SCG_RESP_OKAY;
            sleep_clock_gate_ctrl_one <= SCG_RST_SLEEP_GATE; // [RL1] [RL4]
        end else begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            sleep_clock_gate_ctrl_one <= next_sleep_clock_gate_ctrl_one;
        end
    end

    // read path: one read in flight, answered the cycle after it is taken
    always_comb begin
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (rvalid && s_axi_rready_i) begin
            next_rvalid = 1'b0;
        end
        if (ar_fire) begin
            next_rvalid = 1'b1;
            next_rdata = rd_hit ? (sleep_clock_gate_ctrl_one & SCG_RW_MASK) : '0; // [RL11]
            next_rresp = rd_hit ? SCG_RESP_OKAY : SCG_RESP_SLVERR;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= SCG_RESP_OKAY;
        end else begin
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    // source of the unit enables; without auto gating the run values rule
    always_comb begin
        src = SCG_SRC_RUN;
        if (auto_clock_gate_select_i && deep_sleep_mode_i) begin
            src = SCG_SRC_DEEP;
        end else if (auto_clock_gate_select_i && sleep_mode_i) begin
            src = SCG_SRC_SLEEP; // [RL5]
        end
        unique case (src)
            SCG_SRC_RUN: sel_gate = run_clock_gate_ctrl_one_i;
            SCG_SRC_SLEEP: sel_gate = sleep_clock_gate_ctrl_one;
            SCG_SRC_DEEP: sel_gate = deepsleep_clock_gate_ctrl_one_i;
            default: sel_gate = run_clock_gate_ctrl_one_i;
        endcase
    end

    // one gate per unit, picked from its bit position
    for (genvar u = 0; u < SCG_UNITS; u++) begin : g_unit
        assign unit_en[u] = sel_gate[SCG_UNIT_POS[u]]; // [RL6] [RL7] [RL8] [RL9] [RL10]
        assign sleep_vec[u] = sleep_clock_gate_ctrl_one[SCG_UNIT_POS[u]];
        assign run_vec[u] = run_clock_gate_ctrl_one_i[SCG_UNIT_POS[u]];
        scg_unit_gate u_gate (
            .clk_sys_i(clk_sys_i),
            .resetn_i(resetn_i),
            .enable_i(unit_en[u]), // [RL2]
            .access_i(unit_access_i[u]), // [RL3]
            .unit_o(units_o[u])
        );
        assign unit_clk_en[u] = units_o[u].clk_en;
        assign unit_grant[u] = units_o[u].grant;
        assign unit_fault[u] = units_o[u].fault;
    end

    // outputs
    assign s_axi_awready_o = ~aw_held;
    assign s_axi_wready_o = ~w_held;
    assign s_axi_bvalid_o = bvalid;
    assign s_axi_bresp_o = bresp;
    assign s_axi_arready_o = ~rvalid;
    assign s_axi_rvalid_o = rvalid;
    assign s_axi_rdata_o = rdata;
    assign s_axi_rresp_o = rresp;
    assign sleep_clock_gate_ctrl_one_o = sleep_clock_gate_ctrl_one;
    assign gate_source_o = src;

    // checks on the design's own outputs
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    chk_reset_clear: assert property ( // [RL4]
        @(posedge clk_sys_i) disable iff (1'b0)
        !resetn_i |=> sleep_clock_gate_ctrl_one == SCG_RST_SLEEP_GATE
            && unit_clk_en == '0)
        else $error("gating state not cleared by reset");

    chk_reserved_zero: assert property ( // [RL11]
        (sleep_clock_gate_ctrl_one & ~SCG_RW_MASK) == '0)
        else $error("reserved gating bit set");

    chk_write_full: assert property ( // [RL12]
        commit && wr_hit && w_strb == 4'hf
        |=> sleep_clock_gate_ctrl_one == ($past(w_data) & SCG_RW_MASK)
            && bvalid && bresp == SCG_RESP_OKAY)
        else $error("full write not stored");

    chk_write_miss: assert property ( // [RL1]
        commit && !wr_hit
        |=> $stable(sleep_clock_gate_ctrl_one) && bresp == SCG_RESP_SLVERR)
        else $error("unmapped write changed register");

    chk_hold_value: assert property ( // [RL12]
        !commit |=> $stable(sleep_clock_gate_ctrl_one))
        else $error("gating bits changed without write");

    chk_read_back: assert property ( // [RL12]
        ar_fire && rd_hit
        |=> rvalid && rdata == $past(sleep_clock_gate_ctrl_one)
            && rresp == SCG_RESP_OKAY)
        else $error("read data differs from register");

    chk_sleep_apply: assert property ( // [RL5]
        auto_clock_gate_select_i && sleep_mode_i && !deep_sleep_mode_i
        |=> unit_clk_en == $past(sleep_vec))
        else $error("sleep gating not applied");

    chk_run_apply: assert property ( // [RL5]
        !auto_clock_gate_select_i |=> unit_clk_en == $past(run_vec))
        else $error("run gating not applied without auto gate");

    chk_unit_map: assert property ( // [RL6] [RL7] [RL8] [RL9] [RL10]
        sleep_vec == {sleep_clock_gate_ctrl_one[SCG_BIT_CMP1],
            sleep_clock_gate_ctrl_one[SCG_BIT_CMP0],
            sleep_clock_gate_ctrl_one[SCG_BIT_CNT3:SCG_BIT_CNT0],
            sleep_clock_gate_ctrl_one[SCG_BIT_I2C_UNIT1_GATE],
            sleep_clock_gate_ctrl_one[SCG_BIT_I2C_UNIT0_GATE],
            sleep_clock_gate_ctrl_one[SCG_BIT_SYNC1:SCG_BIT_SYNC0],
            sleep_clock_gate_ctrl_one[SCG_BIT_ASYNC1:SCG_BIT_ASYNC0]})
        else $error("unit bit map wrong");

    chk_fault_off: assert property ( // [RL3]
        |unit_access_i
        |=> unit_fault == ($past(unit_access_i) & ~$past(unit_clk_en))
            && unit_grant == ($past(unit_access_i) & $past(unit_clk_en)))
        else $error("unclocked access not faulted");

    cov_write_hit: cover property (commit && wr_hit ##1 bvalid);
    cov_read_hit: cover property (ar_fire && rd_hit ##1 rvalid);
    cov_fault: cover property (|unit_fault);
    cov_sleep_on: cover property (src == SCG_SRC_SLEEP && |sleep_vec);
endmodule

// >>> tb/test_sleep_mode_clock_gating.sv
// self-checking bench for scg_ctrl: register access over axi4-lite and unit gating
// assumes scg_pkg and the scg_ctrl design files are compiled before this file
`timescale 1ns/1ps
module test_sleep_mode_clock_gating;
    import scg_pkg::*;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [SCG_ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [SCG_DATA_W-1:0] wdata = '0, rdata, run_val = '0, deep_val = '0, reg_out;
    logic [SCG_DATA_W-1:0] model_reg = '0, d;
    logic [3:0] wstrb = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, r;
    logic sleep_m = 1'b0, deep_m = 1'b0, auto_sel = 1'b0;
    logic [SCG_UNITS-1:0] access = '0;
    scg_unit_s [SCG_UNITS-1:0] units;
    scg_src_e src;
    int fail_count = 0;
    int n_tests = 0;
    int seed;

    // 20 MHz system clock
    always #25 clk_sys_i = ~clk_sys_i;

    scg_ctrl i_scg_ctrl (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .sleep_mode_i(sleep_m),
        .deep_sleep_mode_i(deep_m), .auto_clock_gate_select_i(auto_sel),
        .run_clock_gate_ctrl_one_i(run_val), .deepsleep_clock_gate_ctrl_one_i(deep_val),
        .unit_access_i(access), .units_o(units), .sleep_clock_gate_ctrl_one_o(reg_out),
        .gate_source_o(src));

    task automatic stop_test;
        $display("compares %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    // a wait that ran out of its bound ends the run
    task automatic hang(input string what);
        fail_count++;
        $display("FAIL %s expected answer seen none", what);
        stop_test();
    endtask

    // ready is combinational, so it is sampled at the falling edge where it is settled
    task automatic axi_write(input logic [11:0] a, input logic [31:0] dv,
                             input logic [3:0] s, output logic [1:0] rs);
        int n;
        logic ah, wh, bh;
        @(posedge clk_sys_i);
        awaddr <= a;
        wdata <= dv;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        bh = 1'b0;
        while (!bh && n < 50) begin
            @(negedge clk_sys_i);
            ah = awvalid & (awready === 1'b1);
            wh = wvalid & (wready === 1'b1);
            bh = (bvalid === 1'b1);
            rs = bresp;
            @(posedge clk_sys_i);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            n++;
        end
        bready <= 1'b0;
        if (!bh) hang("write response");
    endtask

    task automatic axi_read(input logic [11:0] a, output logic [31:0] dv,
                            output logic [1:0] rs);
        int n;
        logic ah, rh;
        @(posedge clk_sys_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        rh = 1'b0;
        while (!rh && n < 50) begin
            @(negedge clk_sys_i);
            ah = arvalid & (arready === 1'b1);
            rh = (rvalid === 1'b1);
            dv = rdata;
            rs = rresp;
            @(posedge clk_sys_i);
            if (ah) arvalid <= 1'b0;
            n++;
        end
        rready <= 1'b0;
        if (!rh) hang("read response");
    endtask

    // model: only writable bits in enabled byte lanes change
    function automatic logic [31:0] apply(input logic [31:0] old, input logic [31:0] dv,
                                          input logic [3:0] s);
        logic [31:0] m;
        for (int i = 0; i < 4; i++) m[8*i +: 8] = {8{s[i]}};
        m = m & SCG_RW_MASK;
        return (old & ~m) | (dv & m);
    endfunction

    task automatic wr_chk(input logic [31:0] dv, input logic [3:0] s);
        axi_write(SCG_OFS_SLEEP_GATE, dv, s, r);
        model_reg = apply(model_reg, dv, s);
        chk("write resp", SCG_RESP_OKAY, r);
        axi_read(SCG_OFS_SLEEP_GATE, d, r);
        chk("read value", model_reg, d);
        chk("register out", model_reg, reg_out);
    endtask

    // expected enables come from the source picked by the mode inputs
    task automatic check_units;
        logic [31:0] sel;
        logic [SCG_UNITS-1:0] acc;
        scg_src_e es;
        // the caller's mode and sibling values are non-blocking, so read them an edge later
        @(posedge clk_sys_i);
        es = (auto_sel && deep_m) ? SCG_SRC_DEEP : (auto_sel && sleep_m) ? SCG_SRC_SLEEP
            : SCG_SRC_RUN;
        sel = (es == SCG_SRC_DEEP) ? deep_val : (es == SCG_SRC_SLEEP) ? model_reg : run_val;
        acc = SCG_UNITS'($random(seed));
        access <= acc;
        #1;
        chk("source", 32'(es), 32'(src));
        for (int k = 0; k < SCG_UNITS; k++) begin
            chk("clk_en", 32'(sel[SCG_UNIT_POS[k]]), 32'(units[k].clk_en));
        end
        @(posedge clk_sys_i);
        access <= '0;
        #1;
        for (int k = 0; k < SCG_UNITS; k++) begin
            chk("grant", 32'(acc[k] & sel[SCG_UNIT_POS[k]]), 32'(units[k].grant));
            chk("fault", 32'(acc[k] & ~sel[SCG_UNIT_POS[k]]), 32'(units[k].fault));
        end
    endtask

    initial begin
        seed = 98628;
        repeat (12) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        axi_read(SCG_OFS_SLEEP_GATE, d, r);
        chk("reset value", SCG_RST_SLEEP_GATE, d);
        chk("reset resp", SCG_RESP_OKAY, r);
        auto_sel <= 1'b1;
        sleep_m <= 1'b1;
        check_units();
        $display("test reset done");
        // every writable bit set, then reserved ones must still read zero
        wr_chk(32'hffff_ffff, 4'hf);
        wr_chk(32'h0000_0000, 4'hf);
        for (int i = 0; i < 20; i++) begin
            wr_chk($random(seed), 4'($random(seed)));
        end
        $display("test register access done");
        // unmapped places answer an error and leave the register alone
        axi_write(12'h118, 32'hffff_ffff, 4'hf, r);
        chk("unmapped write resp", SCG_RESP_SLVERR, r);
        axi_read(12'h110, d, r);
        chk("unmapped read resp", SCG_RESP_SLVERR, r);
        chk("unmapped read data", 32'h0, d);
        axi_read(SCG_OFS_SLEEP_GATE, d, r);
        chk("value kept", model_reg, d);
        $display("test unmapped done");
        // all mode combinations with random register and sibling values
        for (int i = 0; i < 24; i++) begin
            wr_chk($random(seed), 4'hf);
            run_val <= $random(seed);
            deep_val <= $random(seed);
            auto_sel <= i[0];
            sleep_m <= i[1];
            deep_m <= i[2];
            check_units();
        end
        $display("test unit gating done");
        // a second reset in mid-run clears everything again
        wr_chk(32'hffff_ffff, 4'hf);
        resetn_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        model_reg = SCG_RST_SLEEP_GATE;
        axi_read(SCG_OFS_SLEEP_GATE, d, r);
        chk("second reset value", SCG_RST_SLEEP_GATE, d);
        $display("test second reset done");
        stop_test();
    end
endmodule
